// file: flash_wp_pkg.sv
package flash_wp_pkg;

  // opcodes
  localparam logic [7:0] WRITE_ENABLE_CMD    = 8'h06;
  localparam logic [7:0] WRITE_DISABLE_CMD   = 8'h04;
  localparam logic [7:0] STATUS_WRITE_CMD    = 8'h01;
  localparam logic [7:0] PAGE_PROGRAM_CMD    = 8'h02;
  localparam logic [7:0] FOUR_KB_WIPE_CMD    = 8'h20;
  localparam logic [7:0] HALF_BLOCK_WIPE_CMD = 8'h52;
  localparam logic [7:0] BLOCK_WIPE_CMD      = 8'hD8;
  localparam logic [7:0] CHIP_WIPE_CMD       = 8'hC7;
  localparam logic [7:0] CHIP_WIPE_ALT_CMD   = 8'h60;
  localparam logic [7:0] DEEP_DOWN_CMD       = 8'hB9;
  localparam logic [7:0] RELEASE_WAKE_CMD    = 8'hAB;
  localparam logic [7:0] RESET_ENABLE_CMD    = 8'h66;
  localparam logic [7:0] RESET_DEVICE_CMD    = 8'h99;

  // status field positions
  localparam int BUSY_BIT   = 0;
  localparam int LATCH_BIT  = 1;
  localparam int SIZE_LSB   = 2;
  localparam int TOPBOT_BIT = 5;
  localparam int SMALL_BIT  = 6;
  localparam int LOCK0_BIT  = 7;
  localparam int LOCK1_BIT  = 0;
  localparam int COMPL_BIT  = 6;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // array geometry
  localparam int ADDR_W     = 20;
  localparam int PAGE_BYTES = 256;
  localparam int BITS_W     = 12;
  localparam logic [4:0] SECTOR_LOG = 5'h0C;
  localparam logic [4:0] HALF_LOG   = 5'h0F;
  localparam logic [4:0] BLOCK_LOG  = 5'h10;
  localparam logic [4:0] ARRAY_LOG  = 5'h14;

  // frame lengths in bits
  localparam logic [11:0] OPCODE_BITS = 12'h008;
  localparam logic [11:0] ADDR_BITS   = 12'h020;
  localparam logic [11:0] PROG_BITS   = 12'h028;
  localparam logic [11:0] STAT1_BITS  = 12'h010;
  localparam logic [11:0] STAT2_BITS  = 12'h018;

  // timing
  localparam int unsigned SYS_CLK_MHZ       = 100;
  localparam int unsigned POWER_UP_NS       = 10000;
  localparam int unsigned STATUS_WRITE_NS   = 5000;
  localparam int unsigned PROGRAM_NS        = 8000;
  localparam int unsigned SECTOR_WIPE_NS    = 20000;
  localparam int unsigned HALF_WIPE_NS      = 30000;
  localparam int unsigned BLOCK_WIPE_NS     = 40000;
  localparam int unsigned CHIP_WIPE_NS      = 80000;
  localparam int unsigned POWER_UP_CYC      = (POWER_UP_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned STATUS_WRITE_CYC  = (STATUS_WRITE_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned PROGRAM_CYC       = (PROGRAM_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned SECTOR_WIPE_CYC   = (SECTOR_WIPE_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned HALF_WIPE_CYC     = (HALF_WIPE_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned BLOCK_WIPE_CYC    = (BLOCK_WIPE_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned CHIP_WIPE_CYC     = (CHIP_WIPE_NS * SYS_CLK_MHZ + 999) / 1000;

  typedef enum logic [4:0] {
    ST_POWER = 5'b00001,
    ST_IDLE  = 5'b00010,
    ST_STAT  = 5'b00100,
    ST_PROG  = 5'b01000,
    ST_WIPE  = 5'b10000
  } wp_state_t;

endpackage : flash_wp_pkg

// file: flash_write_protection.sv
`timescale 1ns/100ps
module flash_write_protection
  import flash_wp_pkg::*;
#(
  parameter int unsigned POWER_UP_CYCLES     = POWER_UP_CYC,
  parameter int unsigned STATUS_WRITE_CYCLES = STATUS_WRITE_CYC,
  parameter int unsigned PROGRAM_CYCLES      = PROGRAM_CYC,
  parameter int unsigned SECTOR_WIPE_CYCLES  = SECTOR_WIPE_CYC,
  parameter int unsigned HALF_WIPE_CYCLES    = HALF_WIPE_CYC,
  parameter int unsigned BLOCK_WIPE_CYCLES   = BLOCK_WIPE_CYC,
  parameter int unsigned CHIP_WIPE_CYCLES    = CHIP_WIPE_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              spi_clk,
  input  wire logic              spi_cs_n,
  input  wire logic              spi_di,
  input  wire logic              wp_n,
  output logic                   busy_progress_bit,
  output logic                   write_enable_latch,
  output logic [7:0]             status1,
  output logic [7:0]             status2,
  output logic                   deep_power_down,
  output logic                   arr_prog_en,
  output logic                   arr_erase_en,
  output logic [ADDR_W-1:0]      arr_addr,
  output logic [ADDR_W-1:0]      arr_last_addr,
  output logic [7:0]             arr_prog_data
);

  // ---- link domain ----
  logic              started_q;
  logic [BITS_W-1:0] lbits_q;
  logic              tog_q;
  logic [7:0]        sh_q;
  logic [7:0]        lop_q;
  logic [23:0]       laddr_q;
  logic [8:0]        lnum_q;
  logic              busy_q;
  logic              busy_l1_q;
  logic              busy_l2_q;
  logic [7:0]        pbuf [PAGE_BYTES];
  logic [BITS_W-1:0] nbits;
  logic              byte_done;
  logic [7:0]        byte_val;
  logic [8:0]        byte_idx;

  // frame-open flag, cleared while chip select is high
  always_ff @(posedge spi_clk or posedge spi_cs_n or negedge resetn) begin
    if (!resetn || spi_cs_n) begin
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
    end
  end

  // bit counter restarts on first edge, saturates
  always_comb begin
    nbits = 12'h001;
    if (started_q) begin
      nbits = (lbits_q == 12'hFFF) ? lbits_q : lbits_q + 12'h001;
    end
    byte_done = (nbits[2:0] == 3'h0);
    byte_val  = {sh_q[6:0], spi_di};
    byte_idx  = nbits[11:3] - 9'h001;
  end

  // shifter, opcode and address capture
  always_ff @(posedge spi_clk or negedge resetn) begin
    if (!resetn) begin
      lbits_q <= '0;
      tog_q   <= 1'b0;
      sh_q    <= 8'h00;
      lop_q   <= 8'h00;
      laddr_q <= 24'h00_0000;
      lnum_q  <= 9'h000;
    end else begin
      lbits_q <= nbits;
      sh_q    <= byte_val;
      if (!started_q) begin
        tog_q  <= ~tog_q; // marks a frame with clocks
        lnum_q <= 9'h000;
      end
      if (byte_done && byte_idx == 9'h000) begin
        lop_q <= byte_val;
      end
      if (byte_done && byte_idx >= 9'h001 && byte_idx <= 9'h003) begin
        laddr_q <= {laddr_q[15:0], byte_val};
      end
      if (byte_done && byte_idx >= 9'h004 && lnum_q != 9'h100) begin
        lnum_q <= lnum_q + 9'h001;
      end
    end
  end

  // busy into link domain so a running program keeps its data
  always_ff @(posedge spi_clk or negedge resetn) begin
    if (!resetn) begin
      busy_l1_q <= 1'b0;
      busy_l2_q <= 1'b0;
    end else begin
      busy_l1_q <= busy_q;
      busy_l2_q <= busy_l1_q;
    end
  end

  // page data buffer, wraps inside 256 bytes
  always_ff @(posedge spi_clk) begin
    if (byte_done && byte_idx >= 9'h004 && lop_q == PAGE_PROGRAM_CMD && !busy_l2_q) begin
      pbuf[8'(byte_idx - 9'h004)] <= byte_val;
    end
  end

  // ---- system domain ----
  wp_state_t         state_q;
  logic [31:0]       timer_q;
  logic              wel_q;
  logic              dpd_q;
  logic              rst_arm_q;
  logic [5:0]        sr1_q;
  logic              lock1_q;
  logic              compl_q;
  logic              cs1_q;
  logic              cs2_q;
  logic              cs3_q;
  logic              t1_q;
  logic              t2_q;
  logic              seen_q;
  logic              wp1_q;
  logic              wp2_q;
  logic [8:0]        pcount_q;
  logic [8:0]        pidx_q;
  logic [ADDR_W-1:0] paddr_q;
  logic              prog_en_q;
  logic              erase_en_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] last_q;
  logic [7:0]        data_q;

  // sync chip select, frame toggle and protect pin
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cs1_q <= 1'b1;
      cs2_q <= 1'b1;
      cs3_q <= 1'b1;
      t1_q  <= 1'b0;
      t2_q  <= 1'b0;
      wp1_q <= 1'b1;
      wp2_q <= 1'b1;
    end else begin
      cs1_q <= spi_cs_n;
      cs2_q <= cs1_q;
      cs3_q <= cs2_q;
      t1_q  <= tog_q;
      t2_q  <= t1_q;
      wp1_q <= wp_n;
      wp2_q <= wp1_q;
    end
  end

  // erase / page range from base address and size
  function automatic logic [39:0] span(input logic [ADDR_W-1:0] a, input logic [4:0] lg);
    logic [ADDR_W-1:0] m;
    begin
      m    = 20'(21'h1F_FFFF >> (5'h15 - lg));
      span = {a & ~m, a | m};
    end
  endfunction : span

  // true when [lo,hi] touches a protected address
  function automatic logic prot_hit(input logic [ADDR_W-1:0] lo, input logic [ADDR_W-1:0] hi,
                                    input logic sm, input logic tb, input logic cp,
                                    input logic [2:0] bp);
    logic [4:0]        lg;
    logic [20:0]       size;
    logic [ADDR_W-1:0] plo;
    logic [ADDR_W-1:0] phi;
    begin
      if (sm) begin
        lg = (bp[2] && bp[1]) ? ARRAY_LOG : (bp[2] ? HALF_LOG : 5'h0B + {2'b00, bp});
      end else begin
        lg = (bp > 3'h4) ? ARRAY_LOG : 5'h0F + {2'b00, bp};
      end
      size = 21'h00_0001 << lg;
      plo  = tb ? 20'h0_0000 : 20'(21'h10_0000 - size);
      phi  = tb ? 20'(size - 21'h00_0001) : 20'hF_FFFF;
      if (cp) begin
        prot_hit = (bp == 3'h0) || !(lo >= plo && hi <= phi);
      end else begin
        prot_hit = (bp != 3'h0) && (lo <= phi) && (hi >= plo);
      end
    end
  endfunction : prot_hit

  // frame decode, link registers are still while chip select is high
  logic              frame_end;
  logic              whole;
  logic              st_ok;
  logic [4:0]        wlog;
  logic              is_wipe;
  logic [39:0]       wrng;
  logic [39:0]       prng;
  logic [31:0]       wcyc;
  logic [ADDR_W-1:0] faddr;

  always_comb begin
    frame_end = cs2_q && !cs3_q && (t2_q != seen_q);
    whole     = (lbits_q[2:0] == 3'h0);
    faddr     = laddr_q[ADDR_W-1:0];
    st_ok     = wel_q && !lock1_q && !(sr1_q[5] && !wp2_q);
    is_wipe   = 1'b1;
    wlog      = SECTOR_LOG;
    wcyc      = 32'(SECTOR_WIPE_CYCLES);
    if (lop_q == FOUR_KB_WIPE_CMD && lbits_q == ADDR_BITS) begin
      wlog = SECTOR_LOG;
    end else if (lop_q == HALF_BLOCK_WIPE_CMD && lbits_q == ADDR_BITS) begin
      wlog = HALF_LOG;
      wcyc = 32'(HALF_WIPE_CYCLES);
    end else if (lop_q == BLOCK_WIPE_CMD && lbits_q == ADDR_BITS) begin
      wlog = BLOCK_LOG;
      wcyc = 32'(BLOCK_WIPE_CYCLES);
    end else if ((lop_q == CHIP_WIPE_CMD || lop_q == CHIP_WIPE_ALT_CMD)
                 && lbits_q == OPCODE_BITS) begin
      wlog = ARRAY_LOG;
      wcyc = 32'(CHIP_WIPE_CYCLES);
    end else begin
      is_wipe = 1'b0;
    end
    wrng = span(faddr, wlog);
    prng = span(faddr, 5'h08);
  end

  logic wipe_go;
  logic prog_go;
  logic stat_go;
  logic idle_take;

  // accepted commands, all need the latch
  always_comb begin
    idle_take = frame_end && whole && state_q == ST_IDLE && !dpd_q;
    wipe_go   = idle_take && is_wipe && wel_q
                && !prot_hit(wrng[39:20], wrng[19:0], sr1_q[4], sr1_q[3], compl_q, sr1_q[2:0]);
    prog_go   = idle_take && lop_q == PAGE_PROGRAM_CMD && lbits_q >= PROG_BITS && wel_q
                && !prot_hit(prng[39:20], prng[19:0], sr1_q[4], sr1_q[3], compl_q, sr1_q[2:0]);
    stat_go   = idle_take && lop_q == STATUS_WRITE_CMD && lbits_q >= STAT1_BITS && st_ok;
  end

  // control state machine and busy cycles
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= ST_POWER;
      timer_q <= 32'(POWER_UP_CYCLES);
      busy_q  <= 1'b0;
      seen_q  <= 1'b0;
    end else begin
      if (cs2_q && !cs3_q) begin
        seen_q <= t2_q;
      end
      case (state_q)
        ST_POWER: begin
          if (timer_q == 32'h0000_0000) begin
            state_q <= ST_IDLE;
          end else begin
            timer_q <= timer_q - 32'h0000_0001;
          end
        end
        ST_IDLE: begin
          if (stat_go) begin
            state_q <= ST_STAT;
            timer_q <= 32'(STATUS_WRITE_CYCLES);
            busy_q  <= 1'b1;
          end else if (prog_go) begin
            state_q <= ST_PROG;
            timer_q <= 32'(PROGRAM_CYCLES);
            busy_q  <= 1'b1;
          end else if (wipe_go) begin
            state_q <= ST_WIPE;
            timer_q <= wcyc;
            busy_q  <= 1'b1;
          end
        end
        default: begin
          if (timer_q != 32'h0000_0000) begin
            timer_q <= timer_q - 32'h0000_0001;
          end else if (pidx_q >= pcount_q) begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
          end
        end
      endcase
    end
  end

  // write enable latch, deep power-down, software reset arming
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wel_q     <= 1'b0;
      dpd_q     <= 1'b0;
      rst_arm_q <= 1'b0;
    end else begin
      if (busy_q && state_q != ST_IDLE && timer_q == 32'h0000_0000
          && pidx_q >= pcount_q) begin
        wel_q <= 1'b0;
      end
      if (frame_end && state_q == ST_IDLE) begin
        if (dpd_q) begin
          if (lop_q == RELEASE_WAKE_CMD && whole) begin
            dpd_q <= 1'b0;
          end
        end else begin
          rst_arm_q <= whole && lop_q == RESET_ENABLE_CMD && lbits_q == OPCODE_BITS;
          if (whole && lbits_q == OPCODE_BITS) begin
            if (lop_q == WRITE_ENABLE_CMD) begin
              wel_q <= 1'b1;
            end else if (lop_q == WRITE_DISABLE_CMD) begin
              wel_q <= 1'b0;
            end else if (lop_q == DEEP_DOWN_CMD) begin
              dpd_q <= 1'b1;
            end else if (lop_q == RESET_DEVICE_CMD && rst_arm_q) begin
              wel_q <= 1'b0;
            end
          end
        end
      end
    end
  end

  logic sw_reset;
  assign sw_reset = idle_take && lop_q == RESET_DEVICE_CMD && rst_arm_q
                    && lbits_q == OPCODE_BITS;

  // non-volatile protection fields
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sr1_q   <= STATUS_RESET[7:2];
      lock1_q <= STATUS_RESET[LOCK1_BIT];
      compl_q <= STATUS_RESET[COMPL_BIT];
    end else if (stat_go) begin
      // first status byte sits deepest in the shifter
      if (lbits_q >= ADDR_BITS) begin
        sr1_q   <= laddr_q[23:18];
        lock1_q <= laddr_q[8 + LOCK1_BIT];
        compl_q <= laddr_q[8 + COMPL_BIT];
      end else if (lbits_q >= STAT2_BITS) begin
        sr1_q   <= laddr_q[15:10];
        lock1_q <= laddr_q[LOCK1_BIT];
        compl_q <= laddr_q[COMPL_BIT];
      end else begin
        sr1_q <= laddr_q[7:2];
      end
    end else if (sw_reset && lock1_q && !sr1_q[5]) begin
      lock1_q <= 1'b0;
    end
  end

  // array drive: program drives buffered bytes, erase fills FFh
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pcount_q   <= 9'h000;
      pidx_q     <= 9'h000;
      paddr_q    <= '0;
      prog_en_q  <= 1'b0;
      erase_en_q <= 1'b0;
      addr_q     <= '0;
      last_q     <= '0;
      data_q     <= 8'hFF;
    end else begin
      prog_en_q  <= 1'b0;
      erase_en_q <= 1'b0;
      if (prog_go) begin
        pcount_q <= lnum_q;
        pidx_q   <= 9'h000;
        paddr_q  <= faddr;
      end else if (wipe_go) begin
        erase_en_q <= 1'b1;
        addr_q     <= wrng[39:20];
        last_q     <= wrng[19:0];
        data_q     <= 8'hFF;
      end else if (state_q == ST_PROG && pidx_q < pcount_q) begin
        prog_en_q <= 1'b1;
        addr_q    <= {paddr_q[19:8], paddr_q[7:0] + pidx_q[7:0]};
        last_q    <= {paddr_q[19:8], paddr_q[7:0] + pidx_q[7:0]};
        data_q    <= pbuf[pidx_q[7:0]];
        pidx_q    <= pidx_q + 9'h001;
      end
    end
  end

  assign busy_progress_bit  = busy_q;
  assign write_enable_latch = wel_q;
  assign status1            = {sr1_q, wel_q, busy_q};
  assign status2            = {1'b0, compl_q, 5'h00, lock1_q};
  assign deep_power_down    = dpd_q;
  assign arr_prog_en        = prog_en_q;
  assign arr_erase_en       = erase_en_q;
  assign arr_addr           = addr_q;
  assign arr_last_addr      = last_q;
  assign arr_prog_data      = data_q;

  // ---- checks ----
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_cycle_start;
    (state_q == ST_IDLE) ##1 busy_q;
  endsequence

  property p_pwr_hold;
    (state_q == ST_POWER) |-> !busy_q && !wel_q;
  endproperty
  a_pwr_hold: assert property (p_pwr_hold) else $error("busy or latch in power-up");

  property p_whole_byte;
    s_cycle_start |-> $past(lbits_q[2:0], 2) == 3'h0;
  endproperty
  a_whole_byte: assert property (p_whole_byte) else $error("cycle from partial byte");

  property p_latch_needed;
    s_cycle_start |-> $past(wel_q, 2);
  endproperty
  a_latch_needed: assert property (p_latch_needed) else $error("cycle without latch");

  property p_latch_cleared;
    $fell(busy_q) |-> !wel_q;
  endproperty
  a_latch_cleared: assert property (p_latch_cleared) else $error("latch left set");

  property p_dpd_block;
    dpd_q |=> !$rose(busy_q);
  endproperty
  a_dpd_block: assert property (p_dpd_block) else $error("cycle in deep power-down");

  property p_lockdown;
    (lock1_q && !sr1_q[5]) |=> $stable(sr1_q) && $stable(compl_q);
  endproperty
  a_lockdown: assert property (p_lockdown) else $error("status changed in lock-down");

  property p_hw_lock;
    (!lock1_q && sr1_q[5] && !wp2_q) |=> $stable(sr1_q) && $stable(compl_q);
  endproperty
  a_hw_lock: assert property (p_hw_lock) else $error("status changed with pin low");

  property p_busy_state;
    busy_q == (state_q == ST_STAT || state_q == ST_PROG || state_q == ST_WIPE);
  endproperty
  a_busy_state: assert property (p_busy_state) else $error("busy mismatch");

  property p_prog_len;
    prog_en_q |-> pidx_q <= 9'h100 && state_q == ST_PROG;
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("program beyond page");

  property p_erase_ff;
    $rose(erase_en_q) |-> data_q == 8'hFF ##1 !erase_en_q;
  endproperty
  a_erase_ff: assert property (p_erase_ff) else $error("erase pulse malformed");

endmodule : flash_write_protection

// file: spi_host.sv
`timescale 1ns/100ps
module spi_host (
  output logic spi_clk,
  output logic spi_cs_n,
  output logic spi_di
);
  // idle: clock stands still, select high
  initial begin
    spi_clk  = 1'b0;
    spi_cs_n = 1'b1;
    spi_di   = 1'b0;
  end

  // one bit: data set while clock low, taken on the rise
  task automatic put_bit(input logic b);
    spi_di = b;
    #62.5 spi_clk = 1'b1;
    #62.5 spi_clk = 1'b0;
  endtask : put_bit

  // whole frame: opcode, address, data msb first, then stray bits
  task automatic frame(input logic [7:0] q[$], input int extra);
    #37.3 spi_cs_n = 1'b0;
    foreach (q[i]) for (int b = 7; b >= 0; b--) put_bit(q[i][b]);
    for (int b = 0; b < extra; b++) put_bit(1'b1);
    #62.5 spi_cs_n = 1'b1;
    spi_di = ~spi_di; // released line must not hold its last value
  endtask : frame
endmodule : spi_host

// file: tb_flash_write_protection.sv
`timescale 1ns/100ps
module tb_flash_write_protection;
  import flash_wp_pkg::*;
  logic              sys_clk, resetn, wp_n, saw_busy;
  wire logic         spi_clk, spi_cs_n, spi_di;
  logic              busy_progress_bit, write_enable_latch, deep_power_down;
  logic              arr_prog_en, arr_erase_en;
  logic [7:0]        status1, status2, arr_prog_data, e_data, p_data[$];
  logic [ADDR_W-1:0] arr_addr, arr_last_addr, e_first, e_last, p_addr[$];
  int                errors, checked, busy_seen;
  // protect table: sr1, sr2, target address, accepted
  logic [47:0] prot[11] = '{48'h0400_0F00_0000, 48'h0400_0EF0_0001, 48'h0400_1F00_0000,
    48'h2400_00F0_0000, 48'h2400_0100_0001, 48'h4400_0FF0_0000, 48'h4400_0FE0_0001,
    48'h6400_0000_0000, 48'h6400_0010_0001, 48'h0440_0F00_0001, 48'h0440_0EF0_0000};
  // erase table: opcode, first, last
  logic [47:0] er[5] = '{48'h2012_0001_2FFF, 48'h5210_0001_7FFF, 48'hD810_0001_FFFF,
    48'hC700_000F_FFFF, 48'h6000_000F_FFFF};

  flash_write_protection #(.POWER_UP_CYCLES(200), .STATUS_WRITE_CYCLES(20),
    .PROGRAM_CYCLES(260), .SECTOR_WIPE_CYCLES(20), .CHIP_WIPE_CYCLES(40)) i_dut (
    .sys_clk(sys_clk), .resetn(resetn), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .spi_di(spi_di), .wp_n(wp_n), .busy_progress_bit(busy_progress_bit),
    .write_enable_latch(write_enable_latch), .status1(status1), .status2(status2),
    .deep_power_down(deep_power_down), .arr_prog_en(arr_prog_en),
    .arr_erase_en(arr_erase_en), .arr_addr(arr_addr), .arr_last_addr(arr_last_addr),
    .arr_prog_data(arr_prog_data));
  spi_host i_host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_di(spi_di));

  // system clock
  always #5 sys_clk = ~sys_clk;

  // array side monitor
  always @(posedge sys_clk) begin
    if (arr_prog_en === 1'b1) begin
      p_addr.push_back(arr_addr);
      p_data.push_back(arr_prog_data);
    end
    if (arr_erase_en === 1'b1) begin
      e_first = arr_addr;
      e_last  = arr_last_addr;
      e_data  = arr_prog_data;
    end
    if (busy_progress_bit === 1'b1) busy_seen++;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_sim;
    $display("counts: checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cycles

  // send one frame, then poll busy under a bound
  task automatic cmd(input logic [7:0] q[$], input int extra = 0);
    int n;
    int b0;
    n = 0;
    b0 = busy_seen;
    i_host.frame(q, extra);
    cycles(8);
    while (busy_progress_bit !== 1'b0) begin
      cycles(1);
      n++;
      if (n > 20000) begin
        errors++;
        $display("MISMATCH busy wait expected 0 seen 1");
        end_sim();
      end
    end
    saw_busy = (busy_seen != b0);
  endtask : cmd

  task automatic wr_status(input logic [7:0] s1, input logic [7:0] s2);
    cmd('{WRITE_ENABLE_CMD});
    cmd('{STATUS_WRITE_CMD, s1, s2});
  endtask : wr_status

  initial begin
    sys_clk  = 1'b0;
    resetn   = 1'b0;
    wp_n     = 1'b1;
    saw_busy = 1'b0;
    errors   = 0;
    checked  = 0;
    cycles(10);
    chk("reset latch", 0, write_enable_latch);
    chk("reset busy", 0, busy_progress_bit);
    chk("reset status1", 0, status1);
    resetn <= 1'b1;
    cmd('{WRITE_ENABLE_CMD});
    chk("power-up latch", 0, write_enable_latch);
    cycles(150);
    $display("test power-up done");
    cmd('{WRITE_ENABLE_CMD}, 1);
    chk("odd length latch", 0, write_enable_latch);
    cmd('{PAGE_PROGRAM_CMD, 8'h01, 8'h23, 8'hF0, 8'hA5});
    chk("program without latch", 0, saw_busy + p_addr.size());
    cmd('{WRITE_ENABLE_CMD});
    chk("latch set", 1, write_enable_latch);
    cmd('{PAGE_PROGRAM_CMD, 8'h01, 8'h23, 8'hF0, 8'hA5, 8'h3C});
    chk("program busy", 1, saw_busy);
    chk("program count", 2, p_addr.size());
    chk("program addr0", 20'h1_23F0, p_addr[0]);
    chk("program addr1", 20'h1_23F1, p_addr[1]);
    chk("program data0", 8'hA5, p_data[0]);
    chk("program data1", 8'h3C, p_data[1]);
    chk("latch after program", 0, write_enable_latch);
    $display("test program done");
    foreach (er[i]) begin
      cmd('{WRITE_ENABLE_CMD});
      if (i < 3) cmd('{er[i][47:40], 8'h01, 8'h23, 8'h45});
      else cmd('{er[i][47:40]});
      chk("erase busy", 1, saw_busy);
      chk("erase first", er[i][39:20], e_first);
      chk("erase last", er[i][19:0], e_last);
      chk("erase data", 8'hFF, e_data);
      chk("latch after erase", 0, write_enable_latch);
    end
    $display("test erase done");
    wr_status(8'h07, 8'h00);
    chk("volatile bits", 8'h04, status1);
    cmd('{WRITE_ENABLE_CMD});
    cmd('{STATUS_WRITE_CMD, 8'h08, 8'h00}, 3);
    chk("partial status write", 8'h06, status1);
    foreach (prot[i]) begin
      wr_status(prot[i][47:40], prot[i][39:32]);
      chk("status1 fields", prot[i][47:42], status1[7:2]);
      chk("status2 fields", prot[i][39:32], status2);
      cmd('{WRITE_ENABLE_CMD});
      cmd('{FOUR_KB_WIPE_CMD, prot[i][31:24], prot[i][23:16], prot[i][15:8]});
      chk("erase accepted", prot[i][0], saw_busy);
    end
    $display("test protect map done");
    wr_status(8'h04, 8'h01);
    wr_status(8'h00, 8'h00);
    chk("lock-down holds", 8'h06, status1);
    chk("lock-down mode", 8'h01, status2);
    cmd('{RESET_ENABLE_CMD});
    cmd('{RESET_DEVICE_CMD});
    chk("lock-down released", 8'h00, status2);
    wr_status(8'h80, 8'h00);
    wp_n <= 1'b0;
    wr_status(8'h84, 8'h00);
    chk("pin low blocks", 8'h82, status1);
    wp_n <= 1'b1;
    cycles(4);
    wr_status(8'h84, 8'h00);
    chk("pin high allows", 8'h84, status1);
    $display("test lock modes done");
    cmd('{DEEP_DOWN_CMD});
    chk("deep down entered", 1, deep_power_down);
    cmd('{WRITE_ENABLE_CMD});
    chk("deep down ignores", 0, write_enable_latch);
    cmd('{RELEASE_WAKE_CMD});
    chk("deep down left", 0, deep_power_down);
    cmd('{WRITE_ENABLE_CMD});
    chk("latch after wake", 1, write_enable_latch);
    cmd('{WRITE_DISABLE_CMD});
    chk("latch after disable", 0, write_enable_latch);
    $display("test deep power-down done");
    end_sim();
  end
endmodule : tb_flash_write_protection
